// [core/bc_branch_cell.sv]
// Purpose: One branch flip-flop with clear and set strobes
// Assumes: Clear and set come from phase-gated test pulses
// Notes: Set after clear in one strobe leaves the cell set
`timescale 1ns/1ns
`include "bc_regs.svh"

module bc_branch_cell
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Strobes
    input wire logic i_clear,
    input wire logic i_set,
    // State
    output logic o_state,
    output logic o_state_nxt
);
    import bc_pkg::*;

    bc_cell_state_type s_r;
    bc_cell_state_type s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (i_clear)
        begin
            s_nxt.state = 1'h0;
        end
        // A set seen together with its clear still lands
        if (i_set)
        begin
            s_nxt.state = 1'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign o_state = s_r.state;
    assign o_state_nxt = s_nxt.state;

endmodule

// [core/bc_branch_control.sv]
// Purpose: Branch flip-flops, decoder and special instruction logic
// Assumes: Test pulses and fetch enable held level for a time period
// Notes: Registers on Avalon-MM
//
// Operation
// - Bit 16 one, bit 15 zero flags negative overflow
// - Overflow test clears both, branch one sets after
// - Bit 16 zero, bit 15 one sets branch two
// - Low register bit test: reset, then set if one
// - Sign test one: reset, set if write sign
// - Indicators show branch two then branch one
// - Branch two cleared before any new load
// - Plus zero test: clear, set on plus zero
// - Minus zero test: clear, set on all ones
// - Sign test two: clear, set if negative
// - Monitor output follows branch two
// - Decoder gives states 01, differ, 10, 00
// - Special codes 3, 4, 6 decoded from buffer
// - Recognition only while special decode enabled
// - At T07 raise release, inhibit or extend
// - Special flag set at T07, reset T12
// - At T08 read pulse picks Z or G
// - Z select gives program counter, stage two
// - G select gives buffer read, write B
// - Extend pulse sets extend pending flag
// - Inhibit sets, release clears interrupt inhibit
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "bc_regs.svh"

module bc_branch_control
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Avalon-MM slave
    input wire logic [3:0] i_avm_address,
    input wire logic i_avm_read,
    input wire logic i_avm_write,
    input wire logic [31:0] i_avm_writedata,
    input wire logic [3:0] i_avm_byteenable,
    output logic [31:0] o_avm_readdata,
    output logic o_avm_waitrequest,
    // Test pulses from the sequence generator
    input wire logic i_overflow_test_pulse,
    input wire logic i_low_reg_bit_test_pulse,
    input wire logic i_sign_test_pulse_one,
    input wire logic i_sign_test_pulse_two,
    input wire logic i_plus_zero_test_pulse,
    input wire logic i_minus_zero_test_pulse,
    // Tested data
    input wire logic [15:0] i_write_lines,
    input wire logic i_low_reg_bit_signal,
    input wire logic i_buffer_is_plus_zero,
    input wire logic [15:0] i_buffer_reg,
    input wire logic i_special_decode_enable,
    // Timing
    output logic [3:0] o_phase,
    output logic [3:0] o_time_pulse,
    output logic o_phase_entry,
    // Branch states and decoder
    output logic o_branch_one_state,
    output logic o_branch_two_state,
    output logic o_negative_overflow_signal,
    output logic o_positive_overflow_signal,
    output logic o_decode_state_01,
    output logic o_decode_states_differ,
    output logic o_decode_state_10,
    output logic o_decode_state_00,
    // Peripheral equipment
    output logic o_branch_one_monitor,
    output logic o_branch_two_monitor,
    output logic [1:0] o_indicator,
    // Special instruction path
    output logic o_special_flag,
    output logic o_release_recognised_pulse,
    output logic o_inhibit_recognised_pulse,
    output logic o_extend_recognised_pulse,
    output logic o_extend_pending_set,
    output logic o_interrupt_inhibit_set,
    output logic o_interrupt_inhibit_clear,
    output logic o_read_z_select,
    output logic o_read_g_select,
    output logic o_read_program_counter_pulse,
    output logic o_stage_two_pulse,
    output logic o_read_buffer_pulse,
    output logic o_write_b_pulse
);
    import bc_pkg::*;

    bc_top_state_type s_r;
    bc_top_state_type s_nxt;

    logic [3:0] phase;
    logic [3:0] tp;
    logic entry;
    logic b1;
    logic b2;
    logic b1_nxt;
    logic b2_nxt;
    logic b1_clear;
    logic b1_set;
    logic b2_clear;
    logic b2_set;
    logic at_ph2;
    logic at_ph3;
    logic at_ph4;
    logic under;
    logic over;
    logic wl_sign;
    logic minus_zero;
    logic recog;
    logic code_rel;
    logic code_inh;
    logic code_ext;
    logic at_t07;
    logic at_t08;
    logic at_t12;
    logic bus_req;
    logic bus_done;

    bc_phase_timer u_timer
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_run(s_r.run),
        .o_phase(phase),
        .o_time_pulse(tp),
        .o_phase_entry(entry)
    );

    // Strobes fall on the first cycle of each quarter
    assign at_ph2 = entry & phase[1];
    assign at_ph3 = entry & phase[2];
    assign at_ph4 = entry & phase[3];

    assign wl_sign = i_write_lines[15];
    assign under = i_write_lines[15] & ~i_write_lines[14];
    assign over = ~i_write_lines[15] & i_write_lines[14];
    assign minus_zero = (i_write_lines == `BC_MINUS_ZERO);

    // Overflow test clears in phase two, result lands in phase three
    assign b1_clear = (i_overflow_test_pulse & at_ph2)
        | ((i_low_reg_bit_test_pulse | i_sign_test_pulse_one) & at_ph3);
    assign b1_set = (i_overflow_test_pulse & at_ph3 & under)
        | (i_low_reg_bit_test_pulse & at_ph4 & i_low_reg_bit_signal)
        | (i_sign_test_pulse_one & at_ph4 & wl_sign);

    // Every load of branch two follows its own clear strobe
    assign b2_clear = (i_overflow_test_pulse & at_ph2)
        | ((i_plus_zero_test_pulse | i_minus_zero_test_pulse
        | i_sign_test_pulse_two) & at_ph3);
    assign b2_set = (i_overflow_test_pulse & at_ph3 & over)
        | (i_plus_zero_test_pulse & at_ph4 & i_buffer_is_plus_zero)
        | (i_minus_zero_test_pulse & at_ph4 & minus_zero)
        | (i_sign_test_pulse_two & at_ph4 & wl_sign);

    bc_branch_cell u_branch_one
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_clear(b1_clear),
        .i_set(b1_set),
        .o_state(b1),
        .o_state_nxt(b1_nxt)
    );

    bc_branch_cell u_branch_two
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_clear(b2_clear),
        .i_set(b2_set),
        .o_state(b2),
        .o_state_nxt(b2_nxt)
    );

    // Special instruction timing points
    assign at_t07 = entry & phase[0] & (tp == `BC_TP_SPECIAL_TEST);
    assign at_t08 = entry & phase[0] & (tp == `BC_TP_ADDR_READ);
    assign at_t12 = entry & phase[0] & (tp == `BC_TP_SPECIAL_CLEAR);
    assign recog = at_t07 & i_special_decode_enable;
    assign code_rel = (i_buffer_reg == `BC_CODE_RELEASE);
    assign code_inh = (i_buffer_reg == `BC_CODE_INHIBIT);
    assign code_ext = (i_buffer_reg == `BC_CODE_EXTEND);

    // Bus answers one cycle after the request is seen
    assign bus_req = i_avm_read | i_avm_write;
    assign bus_done = bus_req & ~s_r.waitreq;

    always_comb
    begin
        s_nxt = s_r;

        // Branch decoder registered alongside the branch cells
        s_nxt.dec01 = ~b1_nxt & b2_nxt;
        s_nxt.dec_diff = b1_nxt ^ b2_nxt;
        s_nxt.dec10 = b1_nxt & ~b2_nxt;
        s_nxt.dec00 = ~b1_nxt & ~b2_nxt;
        s_nxt.mon1 = b1_nxt;
        s_nxt.mon2 = b2_nxt;
        s_nxt.indicator = {b2_nxt, b1_nxt};
        s_nxt.under = under;
        s_nxt.over = over;

        // Recognition pulses last one clock
        s_nxt.rel = recog & code_rel;
        s_nxt.inh = recog & code_inh;
        s_nxt.ext = recog & code_ext;
        s_nxt.ext_pend_set = recog & code_ext;
        s_nxt.inh_set = recog & code_inh;
        s_nxt.inh_clr = recog & code_rel;

        // Set beats the T12 clear if both ever coincide
        if (recog & (code_rel | code_inh | code_ext))
        begin
            s_nxt.special = 1'h1;
        end
        else if (at_t12)
        begin
            s_nxt.special = 1'h0;
        end

        // Address read steers the fetch path by the special flag
        s_nxt.zsel = at_t08 & i_special_decode_enable & s_r.special;
        s_nxt.gsel = at_t08 & i_special_decode_enable & ~s_r.special;
        s_nxt.pc_rd = s_r.zsel;
        s_nxt.stage = s_r.zsel;
        s_nxt.buf_rd = s_r.gsel;
        s_nxt.b_wr = s_r.gsel;

        // Register access
        s_nxt.waitreq = ~(bus_req & s_r.waitreq);
        if (bus_req & s_r.waitreq)
        begin
            s_nxt.rdata = 32'h0;
            if (i_avm_read)
            begin
                case (i_avm_address)
                    `BC_OFS_CTRL:
                    begin
                        s_nxt.rdata[`BC_CTRL_RUN_BIT] = s_r.run;
                    end
                    `BC_OFS_STATUS:
                    begin
                        s_nxt.rdata[`BC_ST_B1_BIT] = b1;
                        s_nxt.rdata[`BC_ST_B2_BIT] = b2;
                        s_nxt.rdata[`BC_ST_SPECIAL_BIT] = s_r.special;
                        s_nxt.rdata[`BC_ST_TP_LSB +: 4] = tp;
                        s_nxt.rdata[`BC_ST_PHASE_LSB +: 4] = phase;
                    end
                    default:
                    begin
                        s_nxt.rdata = 32'h0;
                    end
                endcase
            end
        end
        // Write lands on the edge that sees waitrequest low
        if (bus_done & i_avm_write & i_avm_byteenable[0]
            & (i_avm_address == `BC_OFS_CTRL))
        begin
            s_nxt.run = i_avm_writedata[`BC_CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_r <= '0;
            s_r.waitreq <= 1'h1;
            s_r.run <= `BC_CTRL_RESET;
            s_r.dec00 <= 1'h1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Timing and branch cells are flops inside the leaves
    assign o_phase = phase;
    assign o_time_pulse = tp;
    assign o_phase_entry = entry;
    assign o_branch_one_state = b1;
    assign o_branch_two_state = b2;

    assign o_avm_readdata = s_r.rdata;
    assign o_avm_waitrequest = s_r.waitreq;
    assign o_negative_overflow_signal = s_r.under;
    assign o_positive_overflow_signal = s_r.over;
    assign o_decode_state_01 = s_r.dec01;
    assign o_decode_states_differ = s_r.dec_diff;
    assign o_decode_state_10 = s_r.dec10;
    assign o_decode_state_00 = s_r.dec00;
    assign o_branch_one_monitor = s_r.mon1;
    assign o_branch_two_monitor = s_r.mon2;
    assign o_indicator = s_r.indicator;
    assign o_special_flag = s_r.special;
    assign o_release_recognised_pulse = s_r.rel;
    assign o_inhibit_recognised_pulse = s_r.inh;
    assign o_extend_recognised_pulse = s_r.ext;
    assign o_extend_pending_set = s_r.ext_pend_set;
    assign o_interrupt_inhibit_set = s_r.inh_set;
    assign o_interrupt_inhibit_clear = s_r.inh_clr;
    assign o_read_z_select = s_r.zsel;
    assign o_read_g_select = s_r.gsel;
    assign o_read_program_counter_pulse = s_r.pc_rd;
    assign o_stage_two_pulse = s_r.stage;
    assign o_read_buffer_pulse = s_r.buf_rd;
    assign o_write_b_pulse = s_r.b_wr;

endmodule

// [core/bc_phase_timer.sv]
// Purpose: Quarter phases and time pulses
// Assumes: Quarter rounded up to whole cycles
// Notes: Holds still while run is low
`timescale 1ns/1ns
`include "bc_regs.svh"

module bc_phase_timer
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Control
    input wire logic i_run,
    // Timing outputs
    output logic [3:0] o_phase,
    output logic [3:0] o_time_pulse,
    output logic o_phase_entry
);
    import bc_pkg::*;

    localparam logic [3:0] QUARTER_LAST = 4'(`BC_QUARTER_CYC - 1);

    bc_timer_state_type s_r;
    bc_timer_state_type s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.entry = 1'h0;
        if (i_run)
        begin
            if (s_r.cnt == QUARTER_LAST)
            begin
                s_nxt.cnt = 4'h0;
                s_nxt.entry = 1'h1;
                s_nxt.phase = {s_r.phase[2:0], s_r.phase[3]};
                if (s_r.phase[3])
                begin
                    s_nxt.tp = (s_r.tp == `BC_TP_LAST) ? `BC_TP_FIRST
                        : s_r.tp + 4'h1;
                end
            end
            else
            begin
                s_nxt.cnt = s_r.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_r.cnt <= 4'h0;
            s_r.phase <= 4'h1;
            s_r.tp <= `BC_TP_FIRST;
            s_r.entry <= 1'h0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign o_phase = s_r.phase;
    assign o_time_pulse = s_r.tp;
    assign o_phase_entry = s_r.entry;

endmodule

// [core/bc_pkg.sv]
// Purpose: State types
// Assumes: Constants come from bc_regs.svh
// Notes: One packed struct per module
package bc_pkg;

    typedef struct packed {
        logic [3:0] cnt;
        logic [3:0] phase;
        logic [3:0] tp;
        logic entry;
    } bc_timer_state_type;

    typedef struct packed {
        logic state;
    } bc_cell_state_type;

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic run;
        logic under;
        logic over;
        logic special;
        logic rel;
        logic inh;
        logic ext;
        logic ext_pend_set;
        logic inh_set;
        logic inh_clr;
        logic zsel;
        logic gsel;
        logic pc_rd;
        logic stage;
        logic buf_rd;
        logic b_wr;
        logic dec01;
        logic dec_diff;
        logic dec10;
        logic dec00;
        logic mon1;
        logic mon2;
        logic [1:0] indicator;
    } bc_top_state_type;

endpackage

// [core/bc_regs.svh]
// Purpose: Offsets, fields, resets and timing counts
// Assumes: 10 MHz clock, 16-byte register window
// Notes: Definitions only
`ifndef BC_REGS_SVH
`define BC_REGS_SVH

// Register byte offsets
`define BC_ADDR_W 4
`define BC_OFS_CTRL 4'h0
`define BC_OFS_STATUS 4'h4

// Control register fields
`define BC_CTRL_RUN_BIT 0
`define BC_CTRL_RESET 1'h1

// Status register fields
`define BC_ST_B1_BIT 0
`define BC_ST_B2_BIT 1
`define BC_ST_SPECIAL_BIT 2
`define BC_ST_TP_LSB 4
`define BC_ST_PHASE_LSB 8

// Timing
`define BC_CLK_NS 100
`define BC_QUARTER_NS 250
`define BC_QUARTER_CYC ((`BC_QUARTER_NS + `BC_CLK_NS - 1) / `BC_CLK_NS)
`define BC_TP_LAST 4'hc
`define BC_TP_FIRST 4'h1
`define BC_TP_SPECIAL_TEST 4'h7
`define BC_TP_ADDR_READ 4'h8
`define BC_TP_SPECIAL_CLEAR 4'hc

// Special order codes held in the buffer register, minus zero on the write lines
`define BC_CODE_RELEASE 16'h0003
`define BC_CODE_INHIBIT 16'h0004
`define BC_CODE_EXTEND 16'h0006
`define BC_MINUS_ZERO 16'hffff

`endif

// [tb/bc_branch_control_checker.sv]
// Purpose: Port assertions
// Assumes: Test pulses held a period
// Notes: Bound to bc_branch_control
`timescale 1ns/1ns
`include "bc_regs.svh"
module bc_branch_control_checker
(
    // Clock and reset
    input logic i_clk_sys,
    input logic i_rst_b,
    // Tests
    input logic i_overflow_test_pulse,
    input logic i_low_reg_bit_test_pulse,
    input logic i_sign_test_pulse_one,
    input logic i_sign_test_pulse_two,
    input logic i_plus_zero_test_pulse,
    input logic i_minus_zero_test_pulse,
    input logic [15:0] i_write_lines,
    input logic i_low_reg_bit_signal,
    input logic i_buffer_is_plus_zero,
    input logic [15:0] i_buffer_reg,
    input logic i_special_decode_enable,
    // Timing
    input logic [3:0] o_phase,
    input logic [3:0] o_time_pulse,
    input logic o_phase_entry,
    input logic o_branch_one_state,
    input logic o_branch_two_state,
    // Special path
    input logic o_special_flag,
    input logic o_release_recognised_pulse,
    input logic o_inhibit_recognised_pulse,
    input logic o_extend_recognised_pulse,
    input logic o_extend_pending_set,
    input logic o_interrupt_inhibit_set,
    input logic o_interrupt_inhibit_clear,
    input logic o_read_z_select,
    input logic o_read_g_select,
    input logic o_read_program_counter_pulse,
    input logic o_stage_two_pulse,
    input logic o_read_buffer_pulse,
    input logic o_write_b_pulse
);
    wire [15:0] wl = i_write_lines;
    wire b1 = o_branch_one_state;
    wire b2 = o_branch_two_state;
    wire ent2 = o_phase_entry && o_phase[1];
    wire ent3 = o_phase_entry && o_phase[2];
    wire ent4 = o_phase_entry && o_phase[3];
    wire fetch = o_phase_entry && o_phase[0] && i_special_decode_enable;
    wire t1 = i_low_reg_bit_test_pulse || i_sign_test_pulse_one;
    wire t2 = i_plus_zero_test_pulse || i_minus_zero_test_pulse
        || i_sign_test_pulse_two;
    wire set2 = (i_plus_zero_test_pulse && i_buffer_is_plus_zero)
        || (i_minus_zero_test_pulse && (&wl))
        || (i_sign_test_pulse_two && wl[15]);
    wire [2:0] code = {i_buffer_reg == `BC_CODE_RELEASE,
        i_buffer_reg == `BC_CODE_INHIBIT, i_buffer_reg == `BC_CODE_EXTEND};
    wire [2:0] recog = {o_release_recognised_pulse,
        o_inhibit_recognised_pulse, o_extend_recognised_pulse};
    wire [1:0] ovr = {wl[15] & ~wl[14], ~wl[15] & wl[14]};
    wire b1src = i_low_reg_bit_test_pulse ? i_low_reg_bit_signal : wl[15];

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    AST_OVER_CLR: assert property (
        ent2 && i_overflow_test_pulse |=> !b1 && !b2)
        else $error("overflow test left a branch set");
    AST_OVER_SET: assert property (
        ent3 && i_overflow_test_pulse |=> {b1, b2} == $past(ovr))
        else $error("overflow result wrong");
    AST_B1_CLR: assert property (ent3 && t1 |=> !b1)
        else $error("branch one not reset");
    AST_B1_SET: assert property (
        ent4 && t1 |=> b1 == $past(b1src))
        else $error("branch one set wrong");
    AST_B2_CLR: assert property (ent3 && t2 |=> !b2)
        else $error("branch two not cleared");
    AST_B2_SET: assert property (
        ent4 && t2 |=> b2 == $past(set2))
        else $error("branch two set wrong");
    AST_SPECIAL: assert property (
        fetch && o_time_pulse == 4'h7 && |code
        |=> o_special_flag && recog == $past(code))
        else $error("special code not recognised");
    AST_CLEAR12: assert property (
        o_phase_entry && o_phase[0] && o_time_pulse == 4'hc
        |=> !o_special_flag)
        else $error("special flag not reset");
    AST_FETCH: assert property (
        fetch && o_time_pulse == 4'h8
        |=> o_read_z_select == $past(o_special_flag)
        && o_read_g_select == !$past(o_special_flag))
        else $error("address read steered wrong");
    AST_NO_ENABLE: assert property (
        !i_special_decode_enable |=> recog == 3'h0)
        else $error("recognition without enable");
    AST_ZPATH: assert property (o_read_z_select |=>
        o_read_program_counter_pulse && o_stage_two_pulse
        && !o_read_buffer_pulse && !o_write_b_pulse)
        else $error("z path pulses wrong");
    AST_GPATH: assert property (o_read_g_select |=>
        o_read_buffer_pulse && o_write_b_pulse
        && !o_read_program_counter_pulse && !o_stage_two_pulse)
        else $error("g path pulses wrong");
    AST_PAIRS: assert property (
        {o_extend_pending_set, o_interrupt_inhibit_set,
        o_interrupt_inhibit_clear} == {recog[0], recog[1], recog[2]})
        else $error("flag side pulses wrong");

    cover property (fetch && code[0]);
    cover property (o_read_g_select);
    cover property (ent3 && i_overflow_test_pulse && wl[15] && !wl[14]);
endmodule

bind bc_branch_control bc_branch_control_checker bc_chk_i (.*);

// [tb/bc_seq_model.sv]
// Purpose: Sequence generator stand-in
// Assumes: Request held until it lands
// Notes: Pulses change at phase one entries
`timescale 1ns/1ns
module bc_seq_model
(
    // Clock and reset
    input logic i_clk_sys,
    input logic i_rst_b,
    // Timing from the block
    input logic i_phase_entry,
    input logic [3:0] i_phase,
    // Request and branch states
    input logic [5:0] i_test_req,
    input logic [1:0] i_branch,
    // Pulses and settled states
    output logic [5:0] o_test_pulses,
    output logic [1:0] o_settled
);
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_test_pulses <= 6'h00;
            o_settled <= 2'h0;
        end
        else if (i_phase_entry && i_phase[0])
        begin
            // Held a whole period, one request at a time
            o_test_pulses <= i_test_req;
            // Only read a period after the test
            o_settled <= i_branch;
        end
    end
endmodule

// [tb/test_branch_condition_control.sv]
// Purpose: Bench for branch control
// Assumes: Three clocks a quarter, twelve a period
// Notes: Tests go through the sequence model
`timescale 1ns/1ns
`include "bc_regs.svh"
module test_branch_condition_control;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic [3:0] i_avm_address = 4'h0;
    logic i_avm_read = 1'b0;
    logic i_avm_write = 1'b0;
    logic [31:0] i_avm_writedata = 32'h0;
    logic [3:0] i_avm_byteenable = 4'hf;
    logic [15:0] i_write_lines = 16'h0;
    logic [15:0] i_buffer_reg = 16'h0;
    logic i_low_reg_bit_signal = 1'b0;
    logic i_buffer_is_plus_zero = 1'b0;
    logic i_special_decode_enable = 1'b0;
    logic [5:0] req = 6'h0;
    logic [5:0] tp;
    logic [1:0] settled, o_indicator;
    logic [31:0] o_avm_readdata, q;
    logic [3:0] o_phase, o_time_pulse;
    logic o_avm_waitrequest, o_phase_entry, o_special_flag;
    logic o_branch_one_state, o_branch_two_state;
    logic o_negative_overflow_signal, o_positive_overflow_signal;
    logic o_decode_state_01, o_decode_states_differ;
    logic o_decode_state_10, o_decode_state_00;
    logic o_branch_one_monitor, o_branch_two_monitor;
    logic o_release_recognised_pulse, o_inhibit_recognised_pulse;
    logic o_extend_recognised_pulse, o_extend_pending_set;
    logic o_interrupt_inhibit_set, o_interrupt_inhibit_clear;
    logic o_read_z_select, o_read_g_select, o_stage_two_pulse;
    logic o_read_program_counter_pulse, o_read_buffer_pulse;
    logic o_write_b_pulse;
    logic [11:0] seen = 12'h0;
    logic clr = 1'b0;
    int bad_count = 0;
    int cmp_count = 0;
    wire i_overflow_test_pulse = tp[0];
    wire i_low_reg_bit_test_pulse = tp[1];
    wire i_sign_test_pulse_one = tp[2];
    wire i_sign_test_pulse_two = tp[3];
    wire i_plus_zero_test_pulse = tp[4];
    wire i_minus_zero_test_pulse = tp[5];
    // b1, b2, low bit, plus zero, test, lines
    localparam logic [23:0] TAB [13] = '{24'h808000, 24'h404000,
        24'h040000, 24'h45ffff, 24'he10000, 24'h410000, 24'h030000,
        24'h828000, 24'h020000, 24'h540000, 24'h05fffe, 24'h438000,
        24'h00c000};

    bc_branch_control bc_branch_control_i (.*);
    bc_seq_model bc_seq_model_i (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_phase_entry(o_phase_entry),
        .i_phase(o_phase),
        .i_test_req(req),
        .i_branch({o_branch_two_state, o_branch_one_state}),
        .o_test_pulses(tp),
        .o_settled(settled)
    );

    initial forever #50 i_clk_sys = ~i_clk_sys;

    always @(posedge i_clk_sys)
        seen <= clr ? 12'h0 : seen | {o_release_recognised_pulse,
            o_inhibit_recognised_pulse, o_extend_recognised_pulse,
            o_extend_pending_set, o_interrupt_inhibit_set,
            o_interrupt_inhibit_clear, o_read_z_select, o_read_g_select,
            o_read_program_counter_pulse, o_stage_two_pulse,
            o_read_buffer_pulse, o_write_b_pulse};

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic avm(input logic w, input logic [3:0] a,
        input logic [31:0] d, input logic [3:0] be);
        int n = 0;
        i_avm_address <= a;
        i_avm_write <= w;
        i_avm_read <= !w;
        i_avm_writedata <= d;
        i_avm_byteenable <= be;
        do
        begin
            @(posedge i_clk_sys);
            n++;
        end
        while (o_avm_waitrequest !== 1'b0 && n < 100);
        q = o_avm_readdata;
        i_avm_read <= 1'b0;
        i_avm_write <= 1'b0;
        // Spare edge between requests
        @(posedge i_clk_sys);
        if (n >= 100)
            chk("bus answer", 32'h0, 32'h1);
    endtask

    task automatic wait_p1;
        int n = 0;
        do
        begin
            @(posedge i_clk_sys);
            n++;
        end
        while (!(o_phase_entry === 1'b1 && o_phase === 4'h1) && n < 50);
    endtask

    task automatic wait_tp(input logic [3:0] t);
        int n = 0;
        while (o_time_pulse !== t && n < 300)
        begin
            @(posedge i_clk_sys);
            n++;
        end
    endtask

    task automatic br_test(input logic [23:0] t);
        logic b1, b2;
        b1 = t[23];
        b2 = t[22];
        i_write_lines <= t[15:0];
        i_low_reg_bit_signal <= t[21];
        i_buffer_is_plus_zero <= t[20];
        req <= 6'h01 << t[19:16];
        wait_p1();
        req <= 6'h00;
        wait_p1();
        @(posedge i_clk_sys);
        chk("branch outputs", {b1, b2, b1, b2, b2, b1, !b1 && b2, b1 ^ b2,
            b1 && !b2, !b1 && !b2, t[15] & ~t[14], ~t[15] & t[14], b2, b1},
            {o_branch_one_state, o_branch_two_state, o_branch_one_monitor,
            o_branch_two_monitor, o_indicator, o_decode_state_01,
            o_decode_states_differ, o_decode_state_10, o_decode_state_00,
            o_negative_overflow_signal, o_positive_overflow_signal,
            settled});
        avm(1'b0, `BC_OFS_STATUS, 32'h0, 4'hf);
        chk("status branches", {30'h0, b2, b1}, q & 32'h7);
    endtask

    task automatic sp_test(input logic [15:0] c, input logic en,
        input logic [11:0] e);
        wait_tp(4'h5);
        clr <= 1'b1;
        i_buffer_reg <= c;
        i_special_decode_enable <= en;
        @(posedge i_clk_sys);
        clr <= 1'b0;
        wait_tp(4'h9);
        chk("special flag", {31'h0, e[5]}, {31'h0, o_special_flag});
        i_special_decode_enable <= 1'b0;
        wait_tp(4'h2);
        chk("flag after clear", 32'h0, {31'h0, o_special_flag});
        chk("special pulses", {20'h0, e}, {20'h0, seen});
    endtask

    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        @(posedge i_clk_sys);
        avm(1'b0, `BC_OFS_CTRL, 32'h0, 4'hf);
        chk("ctrl reset", 32'h1, q);
        avm(1'b0, `BC_OFS_STATUS, 32'h0, 4'hf);
        chk("status reset", 32'h0, q & 32'h7);
        avm(1'b1, `BC_OFS_CTRL, 32'h0, 4'he);
        avm(1'b0, `BC_OFS_CTRL, 32'h0, 4'hf);
        chk("ctrl masked write", 32'h1, q);
        avm(1'b1, `BC_OFS_CTRL, 32'h0, 4'hf);
        avm(1'b0, `BC_OFS_CTRL, 32'h0, 4'hf);
        chk("ctrl written", 32'h0, q);
        avm(1'b1, `BC_OFS_CTRL, 32'h1, 4'hf);
        avm(1'b1, 4'h8, 32'hffffffff, 4'hf);
        avm(1'b0, 4'h8, 32'h0, 4'hf);
        chk("unmapped", 32'h0, q);
        for (int k = 0; k < 13; k++)
            br_test(TAB[k]);
        sp_test(16'h0003, 1'b1, 12'h86c);
        sp_test(16'h0004, 1'b1, 12'h4ac);
        sp_test(16'h0006, 1'b1, 12'h32c);
        sp_test(16'h0103, 1'b1, 12'h013);
        sp_test(16'h0003, 1'b0, 12'h000);
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        bad_count++;
        $display("ERROR watchdog expected end seen timeout");
        conclude();
    end
endmodule
